// ### dcfpc_pkg.sv
`default_nettype none
package dcfpc_pkg;

   localparam int DATA_W = 36;
   localparam int CFG_W  = 8;
   localparam int CFG_N  = 2;

   // register byte addresses on the bus
   localparam logic [7:0] ADDR_AE_OFS = 8'h00;
   localparam logic [7:0] ADDR_AF_OFS = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // configuration register indices, also the order of parallel loading
   localparam logic CFG_IDX_AE = 1'h0;
   localparam logic CFG_IDX_AF = 1'h1;

   localparam logic [CFG_W-1:0] AE_OFS_RST = 8'h02;
   localparam logic [CFG_W-1:0] AF_OFS_RST = 8'h02;

   // status register field positions
   localparam int STAT_EMPTY_N   = 0;
   localparam int STAT_FULL_N    = 1;
   localparam int STAT_AEMPTY_N  = 2;
   localparam int STAT_AFULL_N   = 3;
   localparam int STAT_HFULL_N   = 4;
   localparam int STAT_VALID_N   = 5;
   localparam int STAT_LEVEL_LSB = 8;

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HRESP_OKAY    = 2'h0;

   typedef struct packed {
      logic              full_clear;
      logic              partial_clear;
      logic [2:0]        word_width_select;
      logic              write_clock;
      logic              write_enable_n;
      logic              input_gate_n;
      logic              config_target_select;
      logic              mailbox_select;
      logic              read_clock;
      logic              read_enable_n;
      logic              output_drive_enable_n;
      logic              mark;
      logic              retransmit_request;
      logic [DATA_W-1:0] data;
   } dcfpc_pins_t;

   typedef struct packed {
      logic half_full_n;
      logic almost_full_n;
      logic almost_empty_n;
      logic full_n;
      logic empty_n;
   } dcfpc_flags_t;

   localparam dcfpc_flags_t FLAGS_RST = '{half_full_n: 1'b1, almost_full_n: 1'b1,
                                          almost_empty_n: 1'b0, full_n: 1'b1, empty_n: 1'b0};

   // word width codes 0..7 select 9,12,16,18,20,24,32,36 bits
   function automatic logic [DATA_W-1:0] width_mask(input logic [2:0] sel);
      logic [DATA_W-1:0] m;
      m = 36'hFFFFFFFFF;
      case (sel)
         3'h0:    m = 36'h0000001FF;
         3'h1:    m = 36'h000000FFF;
         3'h2:    m = 36'h00000FFFF;
         3'h3:    m = 36'h00003FFFF;
         3'h4:    m = 36'h0000FFFFF;
         3'h5:    m = 36'h000FFFFFF;
         3'h6:    m = 36'h0FFFFFFFF;
         default: m = 36'hFFFFFFFFF;
      endcase
      return m;
   endfunction : width_mask

endpackage : dcfpc_pkg
`default_nettype wire

// ### dcfpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcfpc_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);

   logic [W-1:0] stage1;

   // first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         stage1 <= RST_VAL;
         dout   <= RST_VAL;
      end
      else
      begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule : dcfpc_sync
`default_nettype wire

// ### dcfpc_fifo.sv
// Functional notes
// - full clear zeroes pointers and output, resets flags and config to reset values
// - partial clear keeps config, resets the rest
// - one width select serves both ports
// - write edge targets memory or config
// - config uses low eight bits only
// - write enable low writes every edge
// - pointer advances; input gate masks store
// - read edge fetches memory or config
// - read enable low reads every edge
// - output enable low drives data bus
// - valid low marks word on bus
// - mark records location of output word
// - mark holds until replaced
// - retransmit reloads read pointer from mark
// - mailbox select bypasses the buffer
// - empty flag low when empty, read side
// - full flag low when full, write side
// - almost flags by offsets, half flag at half depth
// - disabled outputs still advance read pointer
`timescale 1ns/1ps
`default_nettype none
module dcfpc_fifo
   import dcfpc_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              full_clear,
   input  wire logic              partial_clear,
   input  wire logic [2:0]        word_width_select,
   input  wire logic              write_clock,
   input  wire logic              write_enable_n,
   input  wire logic              input_gate_n,
   input  wire logic              config_target_select,
   input  wire logic              mailbox_select,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              read_clock,
   input  wire logic              read_enable_n,
   input  wire logic              output_drive_enable_n,
   input  wire logic              mark,
   input  wire logic              retransmit_request,
   output var  logic [DATA_W-1:0] rd_data,
   output var  logic              rd_data_oe,
   output var  logic              output_valid_n,
   output var  logic              empty_flag_n,
   output var  logic              full_flag_n,
   output var  logic              almost_empty_flag_n,
   output var  logic              almost_full_flag_n,
   output var  logic              half_full_flag_n,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output var  logic              hreadyout,
   output var  logic [1:0]        hresp,
   output var  logic [31:0]       hrdata
);

   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_CNT  = (AW+1)'(DEPTH / 2);

   // active-low enables rest at their idle level so reset shows no request
   localparam dcfpc_pins_t PINS_RST = '{write_enable_n: 1'b1, input_gate_n: 1'b1, config_target_select: 1'b1,
                                        read_enable_n: 1'b1, output_drive_enable_n: 1'b1, default: '0};

   dcfpc_pins_t       pins;
   dcfpc_flags_t      flags;
   logic              wclk_prev;
   logic              rclk_prev;
   logic              retx_prev;
   logic              wr_edge;
   logic              rd_edge;
   logic              retx_edge;
   logic              wr_edge_q;
   logic              rd_edge_q;
   logic              any_clear;
   logic              cfg_clear;
   logic [DATA_W-1:0] mask;
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] mailbox;
   logic [AW:0]       wr_ptr;
   logic [AW:0]       rd_ptr;
   logic [AW:0]       out_ptr;
   logic [AW:0]       mark_ptr;
   logic [AW:0]       level;
   logic [CFG_W-1:0]  level_wide;
   logic [CFG_W-1:0]  space_wide;
   logic [CFG_W-1:0]  cfg [CFG_N];
   logic              cfg_wr_idx;
   logic              cfg_rd_idx;
   logic              do_write;
   logic              do_read;
   logic              ahb_wr_pend;
   logic [7:0]        ahb_addr;
   logic [31:0]       next_hrdata;

   // every link pin crosses into clk through two flops, clocks included
   dcfpc_sync #(
      .W      ($bits(dcfpc_pins_t)),
      .RST_VAL(PINS_RST)
   ) u_sync (
      .clk  (clk),
      .rst_b(rst_b),
      .din  ({full_clear, partial_clear, word_width_select, write_clock, write_enable_n,
              input_gate_n, config_target_select, mailbox_select, read_clock, read_enable_n,
              output_drive_enable_n, mark, retransmit_request, wr_data}),
      .dout (pins)
   );

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wclk_prev <= 1'b0;
         rclk_prev <= 1'b0;
         retx_prev <= 1'b0;
         wr_edge_q <= 1'b0;
         rd_edge_q <= 1'b0;
      end
      else
      begin
         wclk_prev <= pins.write_clock;
         rclk_prev <= pins.read_clock;
         retx_prev <= pins.retransmit_request;
         // delayed strobes let the flags see the pointers after they moved
         wr_edge_q <= wr_edge;
         rd_edge_q <= rd_edge;
      end
   end

   assign wr_edge   = pins.write_clock & ~wclk_prev;
   assign rd_edge   = pins.read_clock & ~rclk_prev;
   assign retx_edge = pins.retransmit_request & ~retx_prev;
   assign any_clear = pins.full_clear | pins.partial_clear;
   assign cfg_clear = pins.full_clear;
   assign mask      = width_mask(pins.word_width_select);
   assign level     = wr_ptr - rd_ptr;

   // widened to offset size for the almost comparisons
   assign level_wide = CFG_W'(level);
   assign space_wide = CFG_W'(DEPTH_CNT - level);

   // a write into a full buffer is dropped rather than overwriting unread data
   assign do_write = wr_edge & ~pins.write_enable_n & pins.config_target_select
                     & ~pins.mailbox_select & (level != DEPTH_CNT);
   assign do_read  = rd_edge & ~pins.read_enable_n & pins.config_target_select
                     & ~pins.mailbox_select & (level != '0);

   // ---------------- write side ----------------
   always_ff @(posedge clk)
   begin
      if (!rst_b || any_clear)
         wr_ptr <= '0;
      else if (do_write)
         wr_ptr <= wr_ptr + 1'b1;
   end

   // storage carries no reset; pointers alone define its content
   always_ff @(posedge clk)
   begin
      if (do_write && !pins.input_gate_n)
         mem[wr_ptr[AW-1:0]] <= pins.data & mask;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || any_clear)
         mailbox <= '0;
      else if (wr_edge && !pins.write_enable_n && pins.mailbox_select && !pins.input_gate_n)
         mailbox <= pins.data & mask;
   end

   // ---------------- configuration registers ----------------
   always_ff @(posedge clk)
   begin
      if (!rst_b || cfg_clear)
      begin
         cfg[CFG_IDX_AE] <= AE_OFS_RST;
         cfg[CFG_IDX_AF] <= AF_OFS_RST;
         cfg_wr_idx      <= CFG_IDX_AE;
      end
      else
      begin
         if (pins.partial_clear)
            cfg_wr_idx <= CFG_IDX_AE;
         else if (wr_edge && !pins.write_enable_n && !pins.config_target_select
                  && !pins.mailbox_select)
         begin
            cfg[cfg_wr_idx] <= pins.data[CFG_W-1:0];
            cfg_wr_idx      <= ~cfg_wr_idx;
         end
         // bus write wins over a port load in the same cycle
         if (ahb_wr_pend && ahb_addr == ADDR_AE_OFS)
            cfg[CFG_IDX_AE] <= hwdata[CFG_W-1:0];
         else if (ahb_wr_pend && ahb_addr == ADDR_AF_OFS)
            cfg[CFG_IDX_AF] <= hwdata[CFG_W-1:0];
      end
   end

   // ---------------- read side ----------------
   always_ff @(posedge clk)
   begin
      if (!rst_b || any_clear)
      begin
         rd_ptr   <= '0;
         out_ptr  <= '0;
         mark_ptr <= '0;
      end
      else
      begin
         // a retransmit edge beats a read in the same cycle
         if (retx_edge)
            rd_ptr <= mark_ptr;
         else if (do_read)
         begin
            rd_ptr  <= rd_ptr + 1'b1;
            out_ptr <= rd_ptr;
         end
         if (pins.mark)
            mark_ptr <= out_ptr;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || any_clear)
      begin
         rd_data        <= '0;
         output_valid_n <= 1'b1;
         cfg_rd_idx     <= CFG_IDX_AE;
      end
      else if (rd_edge && !pins.read_enable_n && !retx_edge)
      begin
         if (pins.mailbox_select)
         begin
            rd_data        <= mailbox & mask;
            output_valid_n <= pins.output_drive_enable_n;
         end
         else if (!pins.config_target_select)
         begin
            rd_data        <= {{(DATA_W-CFG_W){1'b0}}, cfg[cfg_rd_idx]};
            cfg_rd_idx     <= ~cfg_rd_idx;
            output_valid_n <= pins.output_drive_enable_n;
         end
         else if (do_read)
         begin
            rd_data        <= mem[rd_ptr[AW-1:0]] & mask;
            output_valid_n <= pins.output_drive_enable_n;
         end
         else
            output_valid_n <= 1'b1; // read from empty buffer
      end
   end

   // one enable for the whole bus; the pad ring makes the high impedance
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rd_data_oe <= 1'b0;
      else
         rd_data_oe <= ~pins.output_drive_enable_n;
   end

   // ---------------- flags ----------------
   // each flag only moves on its own port's clock edge
   always_ff @(posedge clk)
   begin
      if (!rst_b || any_clear)
         flags <= FLAGS_RST;
      else
      begin
         // one cycle after the edge, so the word just moved is counted
         if (rd_edge_q)
         begin
            flags.empty_n        <= (level != '0);
            flags.almost_empty_n <= (level_wide > cfg[CFG_IDX_AE]);
         end
         if (wr_edge_q)
         begin
            flags.full_n        <= (level != DEPTH_CNT);
            flags.half_full_n   <= (level < HALF_CNT);
            flags.almost_full_n <= (space_wide > cfg[CFG_IDX_AF]);
         end
      end
   end

   assign empty_flag_n        = flags.empty_n;
   assign full_flag_n         = flags.full_n;
   assign almost_empty_flag_n = flags.almost_empty_n;
   assign almost_full_flag_n  = flags.almost_full_n;
   assign half_full_flag_n    = flags.half_full_n;

   // ---------------- bus slave ----------------
   // zero wait states: read data is prepared during the address phase
   always_comb
   begin
      next_hrdata = 32'h00000000;
      case (haddr[7:0])
         ADDR_AE_OFS: next_hrdata[CFG_W-1:0] = cfg[CFG_IDX_AE];
         ADDR_AF_OFS: next_hrdata[CFG_W-1:0] = cfg[CFG_IDX_AF];
         ADDR_STATUS:
         begin
            next_hrdata[STAT_EMPTY_N]  = flags.empty_n;
            next_hrdata[STAT_FULL_N]   = flags.full_n;
            next_hrdata[STAT_AEMPTY_N] = flags.almost_empty_n;
            next_hrdata[STAT_AFULL_N]  = flags.almost_full_n;
            next_hrdata[STAT_HFULL_N]  = flags.half_full_n;
            next_hrdata[STAT_VALID_N]  = output_valid_n;
            next_hrdata[STAT_LEVEL_LSB +: AW+1] = level;
         end
         default: next_hrdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ahb_wr_pend <= 1'b0;
         ahb_addr    <= 8'h00;
         hrdata      <= 32'h00000000;
      end
      else if (hready)
      begin
         ahb_wr_pend <= hsel & (htrans == HTRANS_NONSEQ) & hwrite & (haddr[31:8] == 24'h000000);
         ahb_addr    <= haddr[7:0];
         if (hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr[31:8] == 24'h000000)
            hrdata <= next_hrdata;
         else
            hrdata <= 32'h00000000;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;

endmodule : dcfpc_fifo
`default_nettype wire

// ### dcfpc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcfpc_properties
   import dcfpc_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_b,
   input wire logic              full_clear,
   input wire logic              partial_clear,
   input wire logic              write_enable_n,
   input wire logic              read_enable_n,
   input wire logic              output_drive_enable_n,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic              rd_data_oe,
   input wire logic              output_valid_n,
   input wire logic              empty_flag_n,
   input wire logic              full_flag_n,
   input wire logic              half_full_flag_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // clear pins pass a two-flop sync, so allow four cycles
   property p_full_clr; full_clear[*4] |=> rd_data == '0 && !empty_flag_n && full_flag_n; endproperty
   a_full_clr: assert property (p_full_clr) else $error("full clear left state");
   property p_part_clr; partial_clear[*4] |=> rd_data == '0 && output_valid_n && !empty_flag_n; endproperty
   a_part_clr: assert property (p_part_clr) else $error("partial clear left state");
   property p_oe_off; output_drive_enable_n[*5] |-> !rd_data_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("bus driven while disabled");
   property p_oe_on; (!output_drive_enable_n)[*5] |-> rd_data_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("bus not driven while enabled");
   property p_valid_oe; $fell(output_valid_n) |-> rd_data_oe; endproperty
   a_valid_oe: assert property (p_valid_oe) else $error("valid without driven bus");
   property p_valid_rd; $fell(output_valid_n) |-> !read_enable_n; endproperty
   a_valid_rd: assert property (p_valid_rd) else $error("valid without read");
   property p_empty_rd; $rose(empty_flag_n) |-> !read_enable_n; endproperty
   a_empty_rd: assert property (p_empty_rd) else $error("empty flag moved off read side");
   property p_full_wr; $fell(full_flag_n) |-> !write_enable_n; endproperty
   a_full_wr: assert property (p_full_wr) else $error("full flag moved off write side");
   property p_half_wr; $fell(half_full_flag_n) |-> !write_enable_n; endproperty
   a_half_wr: assert property (p_half_wr) else $error("half flag moved off write side");
   property p_rst_flags; $rose(rst_b) |-> !empty_flag_n && full_flag_n; endproperty
   a_rst_flags: assert property (p_rst_flags) else $error("flags wrong after reset");
endmodule : dcfpc_properties

bind dcfpc_fifo dcfpc_properties i_dcfpc_properties (.clk, .rst_b, .full_clear, .partial_clear, .write_enable_n,
   .read_enable_n, .output_drive_enable_n, .rd_data, .rd_data_oe, .output_valid_n, .empty_flag_n, .full_flag_n,
   .half_full_flag_n);
`default_nettype wire

// ### dcfpc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcfpc_link_model (
   input  wire logic        clk,
   output var  logic        write_clock,
   output var  logic        write_enable_n,
   output var  logic        input_gate_n,
   output var  logic [35:0] wr_data,
   output var  logic        read_clock,
   output var  logic        read_enable_n
);
   // link clocks stand still between words
   initial
   begin
      write_clock = 1'h0;
      write_enable_n = 1'h1;
      input_gate_n = 1'h1;
      wr_data = 36'h0;
      read_clock = 1'h0;
      read_enable_n = 1'h1;
   end

   task automatic wr1(input logic [35:0] d, input logic g);
      write_enable_n <= 1'h0;
      input_gate_n <= g;
      wr_data <= d;
      repeat (4) @(posedge clk);
      write_clock <= 1'h1;
      repeat (4) @(posedge clk);
      write_clock <= 1'h0;
   endtask : wr1

   // writer only ever sends whole pairs
   task automatic wr2(input logic [35:0] d0, input logic [35:0] d1, input logic [1:0] g);
      wr1(d0, g[0]);
      wr1(d1, g[1]);
      repeat (2) @(posedge clk);
      write_enable_n <= 1'h1;
      wr_data <= ~d1;
      @(posedge clk);
   endtask : wr2

   // enable held past the output update so flags see it
   task automatic rd();
      read_enable_n <= 1'h0;
      repeat (4) @(posedge clk);
      read_clock <= 1'h1;
      repeat (4) @(posedge clk);
      read_clock <= 1'h0;
      repeat (2) @(posedge clk);
      read_enable_n <= 1'h1;
      @(posedge clk);
   endtask : rd
endmodule : dcfpc_link_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dcfpc_pkg::*;
   logic clk = 1'h0, rst_b = 1'h0, full_clear = 1'h0, partial_clear = 1'h0, mark = 1'h0, retransmit_request = 1'h0;
   logic config_target_select = 1'h1, mailbox_select = 1'h0, output_drive_enable_n = 1'h0, hsel = 1'h1, hwrite = 1'h0;
   logic [2:0] word_width_select = 3'h7, hsize = 3'h2;
   logic [1:0] htrans = 2'h0, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [35:0] wr_data, rd_data;
   logic write_clock, write_enable_n, input_gate_n, read_clock, read_enable_n, rd_data_oe, output_valid_n, hreadyout;
   logic empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
   int error_cnt = 0, check_count = 0;
   int wd[8] = '{9, 12, 16, 18, 20, 24, 32, 36};

   always #20 clk = ~clk;

   dcfpc_fifo #(.DEPTH(8)) i_dcfpc_fifo (.clk, .rst_b, .full_clear, .partial_clear, .word_width_select,
      .write_clock, .write_enable_n, .input_gate_n, .config_target_select, .mailbox_select, .wr_data, .read_clock,
      .read_enable_n, .output_drive_enable_n, .mark, .retransmit_request, .rd_data, .rd_data_oe, .output_valid_n,
      .empty_flag_n, .full_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .half_full_flag_n, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
   dcfpc_link_model i_dcfpc_link_model (.clk, .write_clock, .write_enable_n, .input_gate_n, .wr_data,
      .read_clock, .read_enable_n);

   task automatic final_report();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask : chk

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      r = hrdata;
      chk("hresp", HRESP_OKAY, hresp);
      chk("hready", 1'h1, hreadyout);
   endtask : bus

   task automatic rdreg(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'h0, 32'h0);
      chk("register", e, r);
   endtask : rdreg

   task automatic lrd(input logic [35:0] e, input logic v);
      i_dcfpc_link_model.rd();
      chk("valid_n", v, output_valid_n);
      if (!v)
         chk("rd_data", e, rd_data);
   endtask : lrd

   task automatic pulse(input logic [3:0] s);
      {full_clear, partial_clear, retransmit_request, mark} <= s;
      repeat (5) @(posedge clk);
      {full_clear, partial_clear, retransmit_request, mark} <= 4'h0;
      repeat (4) @(posedge clk);
   endtask : pulse

   initial
   begin
      #200000;
      error_cnt++;
      final_report();
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      chk("empty_n", 1'h0, empty_flag_n);
      chk("full_n", 1'h1, full_flag_n);
      rdreg(ADDR_AE_OFS, AE_OFS_RST);
      rdreg(ADDR_AF_OFS, AF_OFS_RST);
      rdreg(8'h0C, 32'h0);
      bus(ADDR_AE_OFS, 1'h1, 32'h5);
      rdreg(ADDR_AE_OFS, 32'h5);
      i_dcfpc_link_model.wr2(36'hA1, 36'hB2, 2'h0);
      i_dcfpc_link_model.wr2(36'hC3, 36'hD4, 2'h1);
      lrd(36'hA1, 1'h0);
      lrd(36'hB2, 1'h0);
      i_dcfpc_link_model.rd();
      lrd(36'hD4, 1'h0);
      lrd(36'h0, 1'h1);
      rdreg(ADDR_STATUS, 32'h2A);
      for (int i = 0; i < 8; i++)
      begin
         word_width_select <= i[2:0];
         repeat (4) @(posedge clk);
         i_dcfpc_link_model.wr2(36'hFFFFFFFFF, 36'hFFFFFFFFF, 2'h0);
         lrd((36'h1 << wd[i]) - 36'h1, 1'h0);
         lrd((36'h1 << wd[i]) - 36'h1, 1'h0);
      end
      output_drive_enable_n <= 1'h1;
      i_dcfpc_link_model.wr2(36'hE5, 36'hF6, 2'h0);
      lrd(36'h0, 1'h1);
      chk("oe", 1'h0, rd_data_oe);
      output_drive_enable_n <= 1'h0;
      lrd(36'hF6, 1'h0);
      chk("oe", 1'h1, rd_data_oe);
      i_dcfpc_link_model.wr2(36'h10, 36'h11, 2'h0);
      i_dcfpc_link_model.wr2(36'h12, 36'h13, 2'h0);
      lrd(36'h10, 1'h0);
      pulse(4'h1);
      lrd(36'h11, 1'h0);
      pulse(4'h2);
      for (int j = 0; j < 4; j++)
         lrd(36'h10 + j, 1'h0);
      lrd(36'h0, 1'h1);
      pulse(4'h2);
      lrd(36'h10, 1'h0);
      pulse(4'h4);
      chk("empty_n", 1'h0, empty_flag_n);
      rdreg(ADDR_AE_OFS, 32'h5);
      config_target_select <= 1'h0;
      i_dcfpc_link_model.wr2(36'hFFFFFFF03, 36'hABCDE0004, 2'h0);
      rdreg(ADDR_AE_OFS, 32'h3);
      rdreg(ADDR_AF_OFS, 32'h4);
      lrd(36'h3, 1'h0);
      lrd(36'h4, 1'h0);
      config_target_select <= 1'h1;
      pulse(4'h8);
      rdreg(ADDR_AE_OFS, AE_OFS_RST);
      mailbox_select <= 1'h1;
      i_dcfpc_link_model.wr2(36'h5A, 36'h5A, 2'h0);
      lrd(36'h5A, 1'h0);
      mailbox_select <= 1'h0;
      chk("empty_n", 1'h0, empty_flag_n);
      chk("aempty_n", 1'h0, almost_empty_flag_n);
      for (int k = 0; k < 4; k++)
         i_dcfpc_link_model.wr2(36'h20, 36'h21, 2'h0);
      chk("full_n", 1'h0, full_flag_n);
      chk("half_n", 1'h0, half_full_flag_n);
      chk("afull_n", 1'h0, almost_full_flag_n);
      lrd(36'h20, 1'h0);
      chk("empty_n", 1'h1, empty_flag_n);
      chk("aempty_n", 1'h1, almost_empty_flag_n);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
